/* verilog/btio_regs.vh */
// Functional notes
// - Non-branching instruction advances program counter by its byte length.
// - Relative branch target is next instruction address plus 8-bit displacement.
// - Displacement is signed; bit 7 sign-extends, reach -128 to +127.
// - Short jump and all conditional branches use relative target.
// - 16-bit immediate call and jump load the full immediate address.
// - Short-page call target lies within 0800H to 0FFFH.
// - Vectored table call uses opcode bits 1-5 to pick entry at 40H-7FH.
// - Register-pair jump copies accumulator pair into program counter.
// - Multiply takes accumulator byte as multiplicand, product into accumulator pair.
// - Word divide reads dividend from and writes quotient to accumulator pair.
// - Both decimal adjusts operate on the accumulator byte.
// - Digit rotates use the accumulator byte as digit holder.
// - Multiply is 8 by 8 bits with 16-bit product in accumulator pair.
`ifndef BTIO_REGS_VH
`define BTIO_REGS_VH

// Branch mode codes.
`define BTIO_MODE_SEQ 3'h0
`define BTIO_MODE_REL 3'h1
`define BTIO_MODE_ABS16 3'h2
`define BTIO_MODE_SHORT 3'h3
`define BTIO_MODE_TABLE 3'h4
`define BTIO_MODE_REGJMP 3'h5

// Implied operand instruction codes.
`define BTIO_OP_NONE 3'h0
`define BTIO_OP_MUL 3'h1
`define BTIO_OP_DIV 3'h2
`define BTIO_OP_ADJ_ADD 3'h3
`define BTIO_OP_ADJ_SUB 3'h4
`define BTIO_OP_ROT_LEFT 3'h5
`define BTIO_OP_ROT_RIGHT 3'h6

// Address windows.
`define BTIO_SHORT_PAGE_BASE 16'h0800
`define BTIO_TABLE_BASE 16'h0040
`define BTIO_PC_RESET 16'h0000

// Register select codes for the general register file.
`define BTIO_SEL_NONE 2'h0
`define BTIO_SEL_ACC_BYTE 2'h1
`define BTIO_SEL_ACC_PAIR 2'h2

`endif

/* verilog/btio_core.v */
`timescale 1ns/1ps
`include "btio_regs.vh"

module btio_core (
    // Clock and reset.
    input wire clk_in,
    input wire rst_n_in,
    // Instruction step from the fetch path.
    input wire step_in,
    input wire [2:0] mode_in,
    input wire [1:0] length_in,
    input wire take_branch_in,
    input wire [7:0] opcode_in,
    input wire [7:0] signed_branch_displacement_in,
    input wire [15:0] immediate_in,
    // Vectored table word read from program memory.
    input wire [15:0] table_word_in,
    // Implied operand request.
    input wire [2:0] implied_op_in,
    input wire [15:0] accumulator_pair_in,
    input wire [7:0] second_operand_in,
    // Program counter and table fetch address.
    output reg [15:0] pc_out,
    output wire [15:0] table_addr_out,
    // Implied operand selection and results.
    output reg [1:0] src_sel_out,
    output reg [1:0] dst_sel_out,
    output reg [15:0] product_out,
    output reg [15:0] quotient_out,
    output reg [7:0] remainder_out
);

    reg [15:0] pc_q;
    reg [15:0] pc_d;
    reg [15:0] product_q;
    reg [15:0] quotient_q;
    reg [7:0] remainder_q;
    wire [16:0] next_seq_sum;
    wire [15:0] next_seq;
    wire [15:0] disp_ext;
    wire [16:0] rel_sum;
    wire [15:0] rel_target;
    wire [15:0] short_target;
    wire [15:0] table_offset;
    wire [15:0] mul_partial [0:8];
    wire [15:0] mul_result;
    wire [8:0] divisor_wide;
    wire [7:0] div_rem [0:16];
    wire [15:0] div_quotient;
    wire [7:0] div_remainder;
    wire divisor_zero;

    // The displacement byte fills the low half and its sign bit fills every upper bit.
    assign disp_ext[7:0] = signed_branch_displacement_in;
    genvar ext_idx;
    generate
        for (ext_idx = 8; ext_idx < 16; ext_idx = ext_idx + 1) begin : g_sign_ext
            assign disp_ext[ext_idx] = signed_branch_displacement_in[7];
        end
    endgenerate

    // The next instruction starts one byte after each byte fetched.
    assign next_seq_sum = {1'b0, pc_q} + {15'h0000, length_in};
    assign next_seq = next_seq_sum[15:0];

    // The sums are a bit wider than the address so that dropping the carry is deliberate:
    // a branch past either end of the space lands at the far end.
    assign rel_sum = {1'b0, next_seq} + {1'b0, disp_ext};
    assign rel_target = rel_sum[15:0];

    // Only the low eleven bits come from the instruction; the base fixes the 2 KB window.
    assign short_target = `BTIO_SHORT_PAGE_BASE |
        {5'h00, immediate_in[10:0]};

    // Shift and add: one adder per multiplier bit keeps the product a plain adder chain.
    assign mul_partial[0] = 16'h0000;
    genvar mul_idx;
    generate
        for (mul_idx = 0; mul_idx < 8; mul_idx = mul_idx + 1) begin : g_mul_stage
            wire [15:0] addend;
            assign addend = second_operand_in[mul_idx] ?
                ({8'h00, accumulator_pair_in[7:0]} << mul_idx) : 16'h0000;
            assign mul_partial[mul_idx + 1] = mul_partial[mul_idx] + addend;
        end
    endgenerate
    assign mul_result = mul_partial[8];

    // Restoring division from the top dividend bit down. Each stage leaves a remainder
    // below the divisor, so eight bits carry it to the next stage.
    // A zero divisor needs no special stage; it is caught where the result is stored.
    assign divisor_wide = {1'b0, second_operand_in};
    assign div_rem[0] = 8'h00;
    genvar div_idx;
    generate
        for (div_idx = 0; div_idx < 16; div_idx = div_idx + 1) begin : g_div_stage
            wire [8:0] trial;
            wire [8:0] diff;
            wire fits;
            assign trial = {div_rem[div_idx], accumulator_pair_in[15 - div_idx]};
            assign diff = trial - divisor_wide;
            assign fits = (trial >= divisor_wide);
            assign div_quotient[15 - div_idx] = fits;
            assign div_rem[div_idx + 1] = fits ? diff[7:0] : trial[7:0];
        end
    endgenerate
    assign div_remainder = div_rem[16];
    assign divisor_zero = (second_operand_in == 8'h00);

    // Entries are two bytes each, so opcode bits 1 to 5 give an even offset.
    assign table_offset = {10'h000, opcode_in[5:1], 1'b0};
    assign table_addr_out = `BTIO_TABLE_BASE | table_offset;

    always @* begin
        pc_d = pc_q;
        if (step_in) begin
            case (mode_in)
                `BTIO_MODE_SEQ: begin
                    pc_d = next_seq;
                end
                `BTIO_MODE_REL: begin
                    // Not-taken conditionals fall through to the next instruction.
                    if (take_branch_in) begin
                        pc_d = rel_target;
                    end else begin
                        pc_d = next_seq;
                    end
                end
                `BTIO_MODE_ABS16: begin
                    pc_d = immediate_in;
                end
                `BTIO_MODE_SHORT: begin
                    pc_d = short_target;
                end
                `BTIO_MODE_TABLE: begin
                    pc_d = table_word_in;
                end
                `BTIO_MODE_REGJMP: begin
                    pc_d = accumulator_pair_in;
                end
                default: begin
                    // Unused mode codes advance like a plain instruction instead of stalling.
                    pc_d = next_seq;
                end
            endcase
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_q <= `BTIO_PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // The counter is shown straight from its register, so it never glitches.
    always @* begin
        pc_out = pc_q;
    end

    // Implied operand routing; results are registered so they are stable for writeback.
    always @* begin
        src_sel_out = `BTIO_SEL_NONE;
        dst_sel_out = `BTIO_SEL_NONE;
        case (implied_op_in)
            `BTIO_OP_MUL: begin
                src_sel_out = `BTIO_SEL_ACC_BYTE;
                dst_sel_out = `BTIO_SEL_ACC_PAIR;
            end
            `BTIO_OP_DIV: begin
                src_sel_out = `BTIO_SEL_ACC_PAIR;
                dst_sel_out = `BTIO_SEL_ACC_PAIR;
            end
            `BTIO_OP_ADJ_ADD, `BTIO_OP_ADJ_SUB: begin
                src_sel_out = `BTIO_SEL_ACC_BYTE;
                dst_sel_out = `BTIO_SEL_ACC_BYTE;
            end
            `BTIO_OP_ROT_LEFT, `BTIO_OP_ROT_RIGHT: begin
                src_sel_out = `BTIO_SEL_ACC_BYTE;
                dst_sel_out = `BTIO_SEL_ACC_BYTE;
            end
            default: begin
                src_sel_out = `BTIO_SEL_NONE;
            end
        endcase
    end

    // Each result register loads only on its own operation, so both can be read later.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            product_q <= 16'h0000;
        end else if (implied_op_in == `BTIO_OP_MUL) begin
            product_q <= mul_result;
        end
    end

    // A zero divisor yields an all-ones quotient and the dividend low byte as remainder,
    // stated outright so that software never depends on what the stage chain happens to do.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quotient_q <= 16'h0000;
            remainder_q <= 8'h00;
        end else if (implied_op_in == `BTIO_OP_DIV) begin
            if (divisor_zero) begin
                quotient_q <= 16'hFFFF;
                remainder_q <= accumulator_pair_in[7:0];
            end else begin
                quotient_q <= div_quotient;
                remainder_q <= div_remainder;
            end
        end
    end

    // Results hold until the same operation runs again, so writeback may come late.
    always @* begin
        product_out = product_q;
        quotient_out = quotient_q;
        remainder_out = remainder_q;
    end

endmodule // btio_core

/* sim/btio_prog_mem.sv */
`timescale 1ns/1ps
module btio_prog_mem (
    // Table fetch.
    input wire [15:0] addr_in,
    output wire [15:0] word_out
);
    // Each word echoes its own address, so a wrong slot cannot pass.
    assign word_out = {addr_in[7:0], ~addr_in[7:0]};
endmodule // btio_prog_mem

/* sim/btio_core_props.sv */
`timescale 1ns/1ps
module btio_core_props (
    // Inputs.
    input wire clk_in, rst_n_in, step_in, take_branch_in,
    input wire [1:0] length_in,
    input wire [2:0] mode_in, implied_op_in,
    input wire [7:0] opcode_in, signed_branch_displacement_in, second_operand_in,
    input wire [15:0] immediate_in, table_word_in, accumulator_pair_in,
    // Outputs.
    input wire [15:0] pc_out, table_addr_out, product_out, quotient_out,
    input wire [7:0] remainder_out,
    input wire [1:0] src_sel_out, dst_sel_out
);
    // Idle cycles map to an unused code to keep antecedents short.
    wire [2:0] m = step_in ? mode_in : 3'h7;
    wire [15:0] nxt = pc_out + length_in;
    wire [15:0] rel = nxt + {{8{signed_branch_displacement_in[7]}}, signed_branch_displacement_in};
    wire [15:0] prod = accumulator_pair_in[7:0] * second_operand_in;
    wire [15:0] quo = accumulator_pair_in / {8'h00, second_operand_in};
    wire [15:0] rem16 = accumulator_pair_in % {8'h00, second_operand_in};
    wire [7:0] rem8 = rem16[7:0];
    wire [7:0] acc_low = accumulator_pair_in[7:0];
    wire div_op = implied_op_in == 3'h2;
    wire zero_div = second_operand_in == 8'h00;
    wire byte_op = implied_op_in >= 3'h3 && implied_op_in <= 3'h6;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_seq_step: assert property ((m == 0 || m == 1 && !take_branch_in)
        |=> pc_out == $past(nxt)) else $error("bad step");
    a_rel_jump: assert property (m == 1 && take_branch_in
        |=> pc_out == $past(rel)) else $error("bad rel");
    a_abs_jump: assert property (m == 2
        |=> pc_out == $past(immediate_in)) else $error("bad abs");
    a_short_call: assert property (m == 3
        |=> pc_out == ($past(immediate_in) & 16'h07FF | 16'h0800)) else $error("bad short");
    a_table_slot: assert property (
        table_addr_out == {10'h001, opcode_in[5:1], 1'b0}) else $error("bad slot");
    a_table_call: assert property (m == 4
        |=> pc_out == $past(table_word_in)) else $error("bad table");
    a_pair_jump: assert property (m == 5
        |=> pc_out == $past(accumulator_pair_in)) else $error("bad pair");
    a_mul_product: assert property (implied_op_in == 1
        |=> product_out == $past(prod)) else $error("bad product");
    a_odd_mode: assert property (step_in && mode_in > 3'h5
        |=> pc_out == $past(nxt)) else $error("bad odd mode");
    a_pc_hold: assert property (!step_in
        |=> $stable(pc_out)) else $error("bad hold");
    a_mul_route: assert property (implied_op_in == 3'h1
        |-> src_sel_out == 2'h1 && dst_sel_out == 2'h2) else $error("bad mul route");
    a_div_route: assert property (div_op
        |-> src_sel_out == 2'h2 && dst_sel_out == 2'h2) else $error("bad div route");
    a_byte_route: assert property (byte_op
        |-> src_sel_out == 2'h1 && dst_sel_out == 2'h1) else $error("bad byte route");
    a_div_quot: assert property (div_op && !zero_div
        |=> quotient_out == $past(quo) && remainder_out == $past(rem8)) else $error("bad quot");
    a_div_zero: assert property (div_op && zero_div
        |=> quotient_out == 16'hFFFF && remainder_out == $past(acc_low)) else $error("bad zero");
endmodule // btio_core_props
bind btio_core btio_core_props u_btio_core_props (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .step_in(step_in),
    .take_branch_in(take_branch_in),
    .length_in(length_in),
    .mode_in(mode_in),
    .implied_op_in(implied_op_in),
    .opcode_in(opcode_in),
    .signed_branch_displacement_in(signed_branch_displacement_in),
    .second_operand_in(second_operand_in),
    .immediate_in(immediate_in),
    .table_word_in(table_word_in),
    .accumulator_pair_in(accumulator_pair_in),
    .pc_out(pc_out),
    .table_addr_out(table_addr_out),
    .product_out(product_out),
    .quotient_out(quotient_out),
    .remainder_out(remainder_out),
    .src_sel_out(src_sel_out),
    .dst_sel_out(dst_sel_out)
);

/* sim/btio_core_bench.sv */
`timescale 1ns/1ps
module btio_core_bench;
    logic clk_in = 0, rst_n_in = 0, step_in = 0, take_branch_in = 0;
    logic [1:0] length_in = 0, src_sel_out, dst_sel_out;
    logic [2:0] mode_in = 0, implied_op_in = 0;
    logic [7:0] opcode_in = 0, signed_branch_displacement_in = 0, second_operand_in = 0;
    logic [7:0] remainder_out;
    logic [15:0] immediate_in = 0, accumulator_pair_in = 0, table_word_in, pc_out;
    logic [15:0] table_addr_out, product_out, quotient_out;
    int err_total = 0, comparisons = 0;
    always #10 clk_in = ~clk_in;
    btio_core u_btio_core (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .step_in(step_in),
        .mode_in(mode_in),
        .length_in(length_in),
        .take_branch_in(take_branch_in),
        .opcode_in(opcode_in),
        .signed_branch_displacement_in(signed_branch_displacement_in),
        .immediate_in(immediate_in),
        .table_word_in(table_word_in),
        .implied_op_in(implied_op_in),
        .accumulator_pair_in(accumulator_pair_in),
        .second_operand_in(second_operand_in),
        .pc_out(pc_out),
        .table_addr_out(table_addr_out),
        .src_sel_out(src_sel_out),
        .dst_sel_out(dst_sel_out),
        .product_out(product_out),
        .quotient_out(quotient_out),
        .remainder_out(remainder_out)
    );
    btio_prog_mem u_btio_prog_mem (.addr_in(table_addr_out), .word_out(table_word_in));
    task automatic check(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [2:0] m, input logic [15:0] exp);
        mode_in = m;
        @(negedge clk_in);
        check(pc_out, exp);
    endtask
    task automatic t_branches();
        step_in = 1;
        length_in = 3;
        step(0, 16'h0003);
        take_branch_in = 1;
        length_in = 2;
        signed_branch_displacement_in = 8'h80;
        step(1, 16'hFF85);
        signed_branch_displacement_in = 8'h7F;
        step(1, 16'h0006);
        take_branch_in = 0;
        step(1, 16'h0008);
        immediate_in = 16'hF3A5;
        step(3, 16'h0BA5);
        step(2, 16'hF3A5);
        opcode_in = 8'h3E;
        step(4, 16'h7E81);
        check(table_addr_out, 16'h007E);
        accumulator_pair_in = 16'h12FF;
        step(5, 16'h12FF);
        step_in = 0;
        step(2, 16'h12FF);
    endtask
    task automatic t_implied();
        second_operand_in = 8'hFF;
        implied_op_in = 3'h1;
        #1 check({src_sel_out, dst_sel_out}, 16'h0006);
        @(negedge clk_in);
        check(product_out, 16'hFE01);
        second_operand_in = 8'h10;
        implied_op_in = 3'h2;
        #1 check({src_sel_out, dst_sel_out}, 16'h000A);
        @(negedge clk_in);
        check(quotient_out, 16'h012F);
        check({8'h00, remainder_out}, 16'h000F);
        check(product_out, 16'hFE01);
        second_operand_in = 8'h00;
        @(negedge clk_in);
        check(quotient_out, 16'hFFFF);
        check({8'h00, remainder_out}, 16'h00FF);
        for (int op = 3; op < 7; op++) begin
            implied_op_in = op[2:0];
            #1 check({src_sel_out, dst_sel_out}, 16'h0005);
            @(negedge clk_in);
        end
        implied_op_in = 3'h7;
        #1 check({src_sel_out, dst_sel_out}, 16'h0000);
        @(negedge clk_in);
        implied_op_in = 3'h0;
        #1 check({src_sel_out, dst_sel_out}, 16'h0000);
        @(negedge clk_in);
    endtask
    task automatic t_reset();
        rst_n_in = 0;
        #1 check(pc_out, 16'h0000);
        check(product_out, 16'h0000);
        check(quotient_out, 16'h0000);
        check({8'h00, remainder_out}, 16'h0000);
        @(negedge clk_in);
        rst_n_in = 1;
        step_in = 1;
        length_in = 1;
        step(6, 16'h0001);
        step(7, 16'h0002);
        step_in = 0;
    endtask
    task automatic complete_run();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        check(pc_out, 16'h0000);
        rst_n_in = 1;
        t_branches();
        t_implied();
        t_reset();
        complete_run();
    end
endmodule // btio_core_bench
